// >>> core/csd_link_engine.sv
// Serial shift engine on the link clock: prescaler, shifter, pin logic
`timescale 1ns/1ps
module csd_link_engine (
    input  wire logic              ser_clk_in,   // Serial unit clock
    input  wire logic              rst_req_in,   // Reset level, other domain
    input  wire logic              start_tgl_in, // Start toggle, other domain
    input  wire logic              cont_req_in,  // Continuous clock request
    input  wire csd_pkg::csd_cfg_t cfg_in,       // Mode and prescaler
    input  wire csd_pkg::csd_word_t tx_in,       // Transmit word
    input  wire logic              sdi_in,       // Serial data pin in
    output logic                   sck_out,      // Serial clock pin
    output logic                   sdo_out,      // Serial data pin out
    output logic                   done_tgl_out, // Done toggle
    output csd_pkg::csd_word_t     rx_out        // Received word, held
);
    typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH, ENG_CONT}
        csd_eng_t;

    // -----------------------------------------------------------------
    // Synchronisers
    // -----------------------------------------------------------------
    logic [2:0] rst_s, start_s, cont_s, sdi_s;
    logic       rst_f, start_f, cont_f, sdi_f;

    always_ff @(posedge ser_clk_in) begin
        rst_s   <= {rst_s[1:0], rst_req_in};
        start_s <= {start_s[1:0], start_tgl_in};
        cont_s  <= {cont_s[1:0], cont_req_in};
        sdi_s   <= {sdi_s[1:0], sdi_in};
        rst_f   <= csd_pkg::csd_agree(rst_s[1], rst_s[2], rst_f);
        start_f <= csd_pkg::csd_agree(start_s[1], start_s[2], start_f);
        cont_f  <= csd_pkg::csd_agree(cont_s[1], cont_s[2], cont_f);
        sdi_f   <= csd_pkg::csd_agree(sdi_s[1], sdi_s[2], sdi_f);
    end

    // -----------------------------------------------------------------
    // Shift engine
    // -----------------------------------------------------------------
    csd_eng_t           st, next_st;
    csd_pkg::csd_cfg_t  cfg, next_cfg;
    logic [9:0]         cnt, next_cnt;
    logic [4:0]         bits, next_bits;
    logic [15:0]        shreg, next_shreg;
    logic               start_seen, next_start_seen;
    logic               next_sck, next_sdo, next_done;
    csd_pkg::csd_word_t next_rx;
    logic               start_ev;
    logic               wide;

    assign start_ev = start_f != start_seen;
    assign wide     = cfg_in.mode == csd_pkg::MODE_16;

    always_comb begin
        next_st         = st;
        next_cfg        = cfg;
        next_cnt        = cnt;
        next_bits       = bits;
        next_shreg      = shreg;
        next_start_seen = start_seen;
        next_sck        = sck_out;
        next_sdo        = sdo_out;
        next_done       = done_tgl_out;
        next_rx         = rx_out;
        case (st)
            ENG_IDLE: begin
                next_sck = 1'b1;
                if (start_ev) begin
                    next_start_seen = start_f;
                    next_cfg        = cfg_in;
                    next_cnt        = csd_pkg::csd_half(cfg_in.cks) - 10'h001;
                    next_sck        = 1'b0;
                    next_st         = ENG_LOW;
                    if (wide) begin
                        next_shreg = tx_in;
                        next_bits  = csd_pkg::BITS_16;
                        next_sdo   = tx_in.upper[7];
                    end else begin
                        next_shreg = {tx_in.lower, 8'h00};
                        next_bits  = csd_pkg::BITS_8;
                        next_sdo   = tx_in.lower[7];
                    end
                end else if (cont_f) begin
                    next_cfg = cfg_in;
                    next_cnt = csd_pkg::csd_half(cfg_in.cks) - 10'h001;
                    next_sck = 1'b0;
                    next_st  = ENG_CONT;
                end
            end
            ENG_LOW: begin
                if (cnt == 10'h000) begin
                    next_sck   = 1'b1;
                    next_shreg = {shreg[14:0], sdi_f};
                    next_bits  = bits - 5'h01;
                    next_cnt   = csd_pkg::csd_half(cfg.cks) - 10'h001;
                    next_st    = ENG_HIGH;
                end else begin
                    next_cnt = cnt - 10'h001;
                end
            end
            ENG_HIGH: begin
                if (cnt != 10'h000) begin
                    next_cnt = cnt - 10'h001;
                end else if (bits == 5'h00) begin
                    next_rx   = (cfg.mode == csd_pkg::MODE_16) ? shreg
                                : {8'h00, shreg[7:0]};
                    next_done = ~done_tgl_out;
                    next_st   = ENG_IDLE;
                end else begin
                    next_sck = 1'b0;
                    next_sdo = shreg[15];
                    next_cnt = csd_pkg::csd_half(cfg.cks) - 10'h001;
                    next_st  = ENG_LOW;
                end
            end
            ENG_CONT: begin
                if (cnt != 10'h000) begin
                    next_cnt = cnt - 10'h001;
                end else if (sck_out && !cont_f) begin
                    next_st = ENG_IDLE;
                end else begin
                    next_sck = ~sck_out;
                    next_cnt = csd_pkg::csd_half(cfg.cks) - 10'h001;
                end
            end
            default: next_st = ENG_IDLE;
        endcase
    end

    always_ff @(posedge ser_clk_in) begin
        if (rst_f) begin
            st           <= ENG_IDLE;
            cfg          <= '0;
            cnt          <= 10'h000;
            bits         <= 5'h00;
            shreg        <= 16'h0000;
            start_seen   <= 1'b0;
            sck_out      <= 1'b1;
            sdo_out      <= 1'b1;
            done_tgl_out <= 1'b0;
            rx_out       <= '0;
        end else begin
            st           <= next_st;
            cfg          <= next_cfg;
            cnt          <= next_cnt;
            bits         <= next_bits;
            shreg        <= next_shreg;
            start_seen   <= next_start_seen;
            sck_out      <= next_sck;
            sdo_out      <= next_sdo;
            done_tgl_out <= next_done;
            rx_out       <= next_rx;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    logic [10:0] edge_cnt;

    always_ff @(posedge ser_clk_in) begin
        edge_cnt <= (sck_out != next_sck) ? 11'h000 : edge_cnt + 11'h001;
    end

    sck_half_a: assert property (
        @(posedge ser_clk_in) disable iff (rst_f)
        (st != ENG_IDLE && sck_out != next_sck)
        |-> edge_cnt + 11'h001 == {1'b0, csd_pkg::csd_half(cfg.cks)})
        else $error("serial clock half period wrong");

    load_narrow_a: assert property (
        @(posedge ser_clk_in) disable iff (rst_f)
        (st == ENG_IDLE && start_ev && cfg_in.mode == csd_pkg::MODE_8)
        |=> shreg[15:8] == $past(tx_in.lower) && bits == csd_pkg::BITS_8)
        else $error("narrow transfer load wrong");

    load_wide_a: assert property (
        @(posedge ser_clk_in) disable iff (rst_f)
        (st == ENG_IDLE && start_ev && wide)
        |=> shreg == $past(tx_in) && sdo_out == $past(tx_in.upper[7]))
        else $error("wide transfer load wrong");
endmodule

// >>> core/csd_pkg.sv
// Package: constants and types of the clocked serial unit
package csd_pkg;
    // -----------------------------------------------------------------
    // Register map (index, byte address is four times the index)
    // -----------------------------------------------------------------
    localparam int          ADDR_W    = 18;
    localparam logic [15:0] IDX_STAT  = 16'hFFA0;
    localparam logic [15:0] IDX_CTRL  = 16'hFFA1;
    localparam logic [15:0] IDX_UPPER = 16'hFFA2;
    localparam logic [15:0] IDX_LOWER = 16'hFFA3;

    // -----------------------------------------------------------------
    // Reset values and field positions
    // -----------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam int          MODE_POS  = 6;
    localparam int          CKS_POS   = 0;
    localparam int          STAT_GO   = 0;
    localparam int          STAT_BUSY = 0;
    localparam int          STAT_CONT = 1;

    // -----------------------------------------------------------------
    // Operating modes and transfer lengths
    // -----------------------------------------------------------------
    localparam logic [1:0]  MODE_8    = 2'h0;
    localparam logic [1:0]  MODE_16   = 2'h1;
    localparam logic [1:0]  MODE_CONT = 2'h2;
    localparam logic [4:0]  BITS_8    = 5'h08;
    localparam logic [4:0]  BITS_16   = 5'h10;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] cks;
    } csd_cfg_t;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
    } csd_word_t;

    function automatic logic [ADDR_W-1:0] csd_addr(input logic [15:0] idx);
        return {idx, 2'h0};
    endfunction

    // Half period of the serial clock in link clock cycles
    function automatic logic [9:0] csd_half(input logic [2:0] cks);
        case (cks)
            3'h0:    return 10'h200;
            3'h1:    return 10'h080;
            3'h2:    return 10'h020;
            3'h3:    return 10'h010;
            3'h4:    return 10'h008;
            3'h5:    return 10'h004;
            3'h6:    return 10'h002;
            default: return 10'h001;
        endcase
    endfunction

    // Synchroniser filter: take the new level once stages two and three agree
    function automatic logic csd_agree(input logic s2, input logic s3,
                                       input logic prev);
        return (s2 == s3) ? s3 : prev;
    endfunction
endpackage

// >>> core/csd_serial_top.sv
// Clocked serial unit: APB register file and link engine
`timescale 1ns/1ps
module csd_serial_top (
    input  wire logic                        ref_clk_in,  // Bus clock
    input  wire logic                        sys_rst_in,  // Sync reset, high
    input  wire logic                        psel_in,     // APB select
    input  wire logic                        penable_in,  // APB enable
    input  wire logic                        pwrite_in,   // APB direction
    input  wire logic [csd_pkg::ADDR_W-1:0]  paddr_in,    // APB byte address
    input  wire logic [31:0]                 pwdata_in,   // APB write data
    output logic      [31:0]                 prdata_out,  // APB read data
    output logic                             pready_out,  // APB ready
    output logic                             pslverr_out, // APB error
    input  wire logic                        ser_clk_in,  // Serial unit clock
    input  wire logic                        sdi_in,      // Serial data in
    output logic                             sck_out,     // Serial clock out
    output logic                             sdo_out      // Serial data out
);
    // -----------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------
    logic [7:0]         ctrl, next_ctrl;
    logic [7:0]         upper, next_upper;
    logic [7:0]         lower, next_lower;
    logic               busy, next_busy;
    logic               start_tgl, next_start_tgl;
    logic               cont_req, next_cont_req;
    logic               done_seen, next_done_seen;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;

    // -----------------------------------------------------------------
    // Done toggle crossing from the link domain
    // -----------------------------------------------------------------
    logic [2:0]         done_s;
    logic               done_f;
    logic               eng_done;
    csd_pkg::csd_word_t eng_rx;

    always_ff @(posedge ref_clk_in) begin
        done_s <= {done_s[1:0], eng_done};
        if (sys_rst_in) begin
            done_f <= 1'b0;
        end else begin
            done_f <= csd_pkg::csd_agree(done_s[1], done_s[2], done_f);
        end
    end

    // -----------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------
    logic [1:0] mode;
    logic       sel_stat, sel_ctrl, sel_upper, sel_lower, hit;
    logic       access, first, commit, done_ev;

    assign mode      = ctrl[csd_pkg::MODE_POS+1:csd_pkg::MODE_POS];
    assign sel_stat  = paddr_in == csd_pkg::csd_addr(csd_pkg::IDX_STAT);
    assign sel_ctrl  = paddr_in == csd_pkg::csd_addr(csd_pkg::IDX_CTRL);
    assign sel_upper = paddr_in == csd_pkg::csd_addr(csd_pkg::IDX_UPPER);
    assign sel_lower = paddr_in == csd_pkg::csd_addr(csd_pkg::IDX_LOWER);
    assign hit       = sel_stat | sel_ctrl | sel_upper | sel_lower;
    assign access    = psel_in & penable_in;
    assign first     = access & ~pready_out;
    assign commit    = access & pready_out & pwrite_in & ~pslverr_out;
    assign done_ev   = done_f != done_seen;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        next_ctrl      = ctrl;
        next_upper     = upper;
        next_lower     = lower;
        next_busy      = busy;
        next_start_tgl = start_tgl;
        next_done_seen = done_seen;
        next_cont_req  = mode == csd_pkg::MODE_CONT;
        next_pready    = first;
        next_pslverr   = first & ~hit;
        next_prdata    = 32'h0000_0000;

        if (first && !pwrite_in) begin
            if (sel_stat) begin
                next_prdata[csd_pkg::STAT_BUSY] = busy;
                next_prdata[csd_pkg::STAT_CONT] = cont_req;
            end
            if (sel_ctrl) begin
                next_prdata[7:0] = ctrl;
            end
            if (sel_upper) begin
                next_prdata[7:0] = upper;
            end
            if (sel_lower) begin
                next_prdata[7:0] = lower;
            end
        end

        if (done_ev) begin
            next_done_seen = done_f;
            next_busy      = 1'b0;
            next_lower     = eng_rx.lower;
            if (mode == csd_pkg::MODE_16) begin
                next_upper = eng_rx.upper;
            end
        end

        // The buffer and the mode stay fixed while a transfer runs
        if (commit && !busy) begin
            if (sel_stat && pwdata_in[csd_pkg::STAT_GO]
                && (mode == csd_pkg::MODE_8
                    || mode == csd_pkg::MODE_16)) begin
                next_busy      = 1'b1;
                next_start_tgl = ~start_tgl;
            end
            if (sel_ctrl) begin
                next_ctrl = pwdata_in[7:0];
            end
            if (sel_upper) begin
                next_upper = pwdata_in[7:0];
            end
            if (sel_lower) begin
                next_lower = pwdata_in[7:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl        <= csd_pkg::CTRL_RST;
            upper       <= csd_pkg::DATA_RST;
            lower       <= csd_pkg::DATA_RST;
            busy        <= 1'b0;
            start_tgl   <= 1'b0;
            cont_req    <= 1'b0;
            done_seen   <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            upper       <= next_upper;
            lower       <= next_lower;
            busy        <= next_busy;
            start_tgl   <= next_start_tgl;
            cont_req    <= next_cont_req;
            done_seen   <= next_done_seen;
            prdata_out  <= next_prdata;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
        end
    end

    // -----------------------------------------------------------------
    // Link engine
    // -----------------------------------------------------------------
    csd_pkg::csd_cfg_t  eng_cfg;
    csd_pkg::csd_word_t eng_tx;

    assign eng_cfg.mode = mode;
    assign eng_cfg.cks  = ctrl[csd_pkg::CKS_POS+2:csd_pkg::CKS_POS];
    assign eng_tx.upper = upper;
    assign eng_tx.lower = lower;

    csd_link_engine u_engine (
        .ser_clk_in   (ser_clk_in),
        .rst_req_in   (sys_rst_in),
        .start_tgl_in (start_tgl),
        .cont_req_in  (cont_req),
        .cfg_in       (eng_cfg),
        .tx_in        (eng_tx),
        .sdi_in       (sdi_in),
        .sck_out      (sck_out),
        .sdo_out      (sdo_out),
        .done_tgl_out (eng_done),
        .rx_out       (eng_rx)
    );

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    start_mode_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (start_tgl != $past(start_tgl))
        |-> ($past(mode) == csd_pkg::MODE_8
             || $past(mode) == csd_pkg::MODE_16) && busy)
        else $error("transfer started in a mode without data");

    upper_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (done_ev && mode == csd_pkg::MODE_8)
        |=> upper == $past(upper) && !busy)
        else $error("upper byte changed by a narrow transfer");

    upper_load_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (done_ev && mode == csd_pkg::MODE_16)
        |=> upper == $past(eng_rx.upper))
        else $error("upper byte not loaded by a wide transfer");

    lower_load_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        done_ev |=> lower == $past(eng_rx.lower))
        else $error("lower byte not loaded by a transfer");

    buffer_lock_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (commit && busy && !done_ev && (sel_upper || sel_lower))
        |=> upper == $past(upper) && lower == $past(lower))
        else $error("data buffer written during a transfer");

    ready_pulse_a: assert property (
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (first && !pwrite_in && sel_lower)
        |=> pready_out && prdata_out == {24'h00_0000, $past(lower)})
        else $error("read answer wrong");
endmodule

// >>> testbench/csd_peer.sv
// Partner model: serial peer clocked by the device
`timescale 1ns/1ps
module csd_peer (
    input  wire logic sck_in,  // Serial clock from device
    input  wire logic sdo_in,  // Data from device
    output logic      sdi_out  // Data to device
);
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    int          idx;

    initial begin
        tx_word = 16'h0000;
        rx_word = 16'h0000;
        idx     = -1;
        sdi_out = 1'b1;
    end

    // Load the reply word, sent MSB first
    task automatic prime(input logic [15:0] word, input int nbits);
        tx_word = word;
        idx     = nbits - 1;
    endtask

    // Next bit on the falling edge; outside a frame the line keeps moving
    always @(negedge sck_in) begin
        if (idx >= 0) begin
            sdi_out <= tx_word[idx];
            idx     <= idx - 1;
        end else begin
            sdi_out <= ~sdi_out;
        end
    end

    always @(posedge sck_in) begin
        rx_word <= {rx_word[14:0], sdo_in};
    end
endmodule

// >>> testbench/test_clocked_serial_config_and_data.sv
// Testbench: registers, serial transfers and serial clock rates
`timescale 1ns/1ps
module test_clocked_serial_config_and_data;
    logic                       ref_clk_in;
    logic                       ser_clk_in;
    logic                       sys_rst_in;
    logic                       psel_in;
    logic                       penable_in;
    logic                       pwrite_in;
    logic [csd_pkg::ADDR_W-1:0] paddr_in;
    logic [31:0]                pwdata_in;
    logic [31:0]                prdata_out;
    logic                       pready_out;
    logic                       pslverr_out;
    logic                       sdi_in;
    logic                       sck_out;
    logic                       sdo_out;
    int                         num_errors;
    int                         checks;
    logic [31:0]                rd;
    logic                       err;
    logic [7:0]                 up;
    logic [7:0]                 lo;
    logic [15:0]                pw;
    logic [1:0]                 md;
    localparam int DIV [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};

    csd_serial_top DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .ser_clk_in(ser_clk_in), .sdi_in(sdi_in), .sck_out(sck_out),
        .sdo_out(sdo_out));
    csd_peer PEER (.sck_in(sck_out), .sdo_in(sdo_out), .sdi_out(sdi_in));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        ser_clk_in = 1'b0;
        #3.3;
        forever #7.5 ser_clk_in = ~ser_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; ready and read data are taken at the rising edge
    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [7:0] wd);
        @(posedge ref_clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= {idx, 2'h0};
        pwdata_in <= {24'h000000, wd};
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'b1);
        rd  = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic measure(input logic [2:0] cks);
        longint t0;
        @(posedge sck_out);
        t0 = $time;
        @(negedge sck_out);
        chk(32'($time - t0), 32'(DIV[cks] / 2 * 15));
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, csd_pkg::IDX_STAT, 8'h00);
            n++;
        end while (rd[0] !== 1'b0 && n < 3000);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk_in);
        num_errors++;
        stop_test();
    end

    initial begin
        num_errors = 0;
        checks     = 0;
        sys_rst_in = 1'b1;
        psel_in    = 1'b0;
        penable_in = 1'b0;
        pwrite_in  = 1'b0;
        paddr_in   = '0;
        pwdata_in  = 32'h00000000;
        void'($urandom(24074));
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        apb(1'b0, csd_pkg::IDX_CTRL, 8'h00);
        chk(rd, 32'h00000000);
        apb(1'b0, csd_pkg::IDX_UPPER, 8'h00);
        chk(rd, 32'h00000000);
        apb(1'b0, 16'hFFA4, 8'h00);
        chk({rd[30:0], err}, 32'h00000001);
        $display("test reset and map done");
        for (int c = 0; c < 5; c++) begin
            md = c[0] ? csd_pkg::MODE_16 : csd_pkg::MODE_8;
            up = c == 0 ? 8'hFF : 8'($urandom);
            lo = c == 0 ? 8'h00 : 8'($urandom);
            pw = c == 0 ? 16'h00FF : 16'($urandom);
            apb(1'b1, csd_pkg::IDX_CTRL, {md, 3'h0, c[2:0]});
            apb(1'b0, csd_pkg::IDX_CTRL, 8'h00);
            chk(rd, {24'h000000, md, 3'h0, c[2:0]});
            apb(1'b1, csd_pkg::IDX_UPPER, up);
            apb(1'b1, csd_pkg::IDX_LOWER, lo);
            apb(1'b0, csd_pkg::IDX_LOWER, 8'h00);
            chk(rd, {24'h000000, lo});
            PEER.prime(pw, c[0] ? 16 : 8);
            apb(1'b1, csd_pkg::IDX_STAT, 8'h01);
            apb(1'b0, csd_pkg::IDX_STAT, 8'h00);
            chk(rd, 32'h00000001);
            // Write while busy must be refused by the buffer lock
            apb(1'b1, csd_pkg::IDX_UPPER, ~up);
            measure(c[2:0]);
            wait_idle();
            apb(1'b0, csd_pkg::IDX_UPPER, 8'h00);
            chk(rd, {24'h000000, c[0] ? pw[15:8] : up});
            apb(1'b0, csd_pkg::IDX_LOWER, 8'h00);
            chk(rd, {24'h000000, pw[7:0]});
            chk({16'h0000, c[0] ? PEER.rx_word : {8'h00, PEER.rx_word[7:0]}},
                {16'h0000, c[0] ? {up, lo} : {8'h00, lo}});
            $display("test transfer %0d done", c);
        end
        for (int c = 5; c < 8; c++) begin
            apb(1'b1, csd_pkg::IDX_CTRL, {csd_pkg::MODE_CONT, 3'h0, c[2:0]});
            measure(c[2:0]);
            apb(1'b0, csd_pkg::IDX_STAT, 8'h00);
            chk(rd, 32'h00000002);
            apb(1'b1, csd_pkg::IDX_CTRL, 8'h00);
            apb(1'b0, csd_pkg::IDX_STAT, 8'h00);
            chk({rd[31:1], sck_out}, 32'h00000001);
            $display("test continuous %0d done", c);
        end
        apb(1'b1, csd_pkg::IDX_CTRL, 8'hC4);
        apb(1'b1, csd_pkg::IDX_STAT, 8'h01);
        apb(1'b0, csd_pkg::IDX_STAT, 8'h00);
        chk({rd[31:1], sck_out}, 32'h00000001);
        $display("test reserved mode done");
        stop_test();
    end
endmodule
